/* rtl/adcc_pkg.sv */
/*
  Shared constants and types of the converter control block: register
  offset, field positions, reset value, trigger and format codes, the
  sequencer states and the bus and control carriers.
  Assumes a 16-bit register port with a small word address.
*/
package adcc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam logic [3:0] CTRL_ONE_OFFSET = 4'h0;
  localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_ENABLE = 15;
  localparam int BIT_IDLE_STOP = 13;
  localparam int BIT_RESOLUTION = 10;
  localparam int BIT_FORMAT_LO = 8;
  localparam int BIT_SOURCE_LO = 5;
  localparam int BIT_SIMUL = 3;
  localparam int BIT_AUTO = 2;
  localparam int BIT_SAMPLING = 1;
  localparam int BIT_DONE = 0;

  // ----------------------------------------------------------------
  // codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_MANUAL = 3'h0;
  localparam logic [2:0] SRC_PIN = 3'h1;
  localparam logic [2:0] SRC_TIMER = 3'h2;
  localparam logic [2:0] SRC_COUNTER = 3'h7;
  localparam logic [1:0] FMT_INTEGER = 2'h0;
  localparam logic [1:0] FMT_SIGNED = 2'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SAMPLE_CYCLES_DEFAULT = 3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } adcc_bus_t;

  typedef struct packed {
    logic enable;
    logic idleStop;
    logic resolution;
    logic [1:0] format;
    logic [2:0] source;
    logic simul;
    logic autoStart;
  } adcc_ctrl_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONV = 2'b10
  } adcc_state_t;

endpackage

/* rtl/adcc_edge.sv */
/*
  Edge detector turning a trigger level into a one-cycle event.
  Assumes the input is synchronous to clk.
*/
`timescale 1ns/10ps
module adcc_edge #(
  parameter bit RISING = 1'b1
) (
  input logic clk,
  input logic rst,
  input logic level,
  output logic pulse
);

  logic prev;

  always_ff @(posedge clk)
  begin
    if (rst)
      prev <= 1'b0;
    else
      prev <= level;
  end

  assign pulse = RISING ? (level & ~prev) : (~level & prev);

endmodule

/* rtl/adcc_format.sv */
/*
  Result formatter: integer or signed presentation of a 10-bit or
  12-bit conversion result, registered.
  Assumes raw is valid in the cycle that inValid is high.
*/
`timescale 1ns/10ps
module adcc_format (
  input logic clk,
  input logic rst,
  input logic inValid,
  input logic [11:0] raw,
  input logic twelveBit,
  input logic [1:0] format,
  output logic [15:0] outData,
  output logic outValid
);
  import adcc_pkg::*;

  // ----------------------------------------------------------------
  // format selection
  // ----------------------------------------------------------------
  wire [15:0] intWord = twelveBit ? {4'h0, raw} : {6'h00, raw[9:0]};
  wire [15:0] sgnWord = twelveBit ? {{5{~raw[11]}}, raw[10:0]}
                                  : {{7{~raw[9]}}, raw[8:0]};
  wire isInt = format == FMT_INTEGER;
  wire isSgn = format == FMT_SIGNED;
  // reserved codes give zero
  wire [15:0] fmtWord = isInt ? intWord : (isSgn ? sgnWord : 16'h0000);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      outData <= 16'h0000;
      outValid <= 1'b0;
    end
    else
    begin
      outValid <= inValid;
      if (inValid)
        outData <= fmtWord;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_fmt_ten_signed: assert property (
    inValid && !twelveBit && format == FMT_SIGNED |=>
      outData[15:10] == {6{~$past(raw[9])}} &&
      outData[8:0] == $past(raw[8:0]))
    else $error("10-bit signed format wrong");

  a_fmt_ten_int: assert property (
    inValid && !twelveBit && format == FMT_INTEGER |=>
      outData == {6'h00, $past(raw[9:0])})
    else $error("10-bit integer format wrong");

  a_fmt_twelve_signed: assert property (
    inValid && twelveBit && format == FMT_SIGNED |=>
      outData[15:12] == {4{~$past(raw[11])}} &&
      outData[10:0] == $past(raw[10:0]))
    else $error("12-bit signed format wrong");

  a_fmt_twelve_int: assert property (
    inValid && twelveBit && format == FMT_INTEGER |=>
      outData == {4'h0, $past(raw)})
    else $error("12-bit integer format wrong");

endmodule

/* rtl/adcc_ctrl.sv */
/*
  Converter control block: the first control register of a successive
  approximation converter and the sample/convert sequencer it steers.
  Assumes a conversion engine that takes convStart with convChannel
  and answers with convDone and convResult, and trigger inputs that are
  synchronous to clk. Channel count comes from the second register.
*/
`timescale 1ns/10ps
module adcc_ctrl #(
  parameter int SAMPLE_CYCLES = adcc_pkg::SAMPLE_CYCLES_DEFAULT
) (
  input logic clk,
  input logic rst,
  input adcc_pkg::adcc_bus_t bus,
  output logic [15:0] rdata,
  input logic idleMode,
  input logic [1:0] channelCount,
  input logic timerCompare,
  input logic extPin,
  input logic convDone,
  input logic [11:0] convResult,
  output logic [3:0] sampleHold,
  output logic convStart,
  output logic [1:0] convChannel,
  output logic [15:0] resultData,
  output logic resultValid,
  output logic converterOn
);
  import adcc_pkg::*;

  localparam int CNT_W = $clog2(SAMPLE_CYCLES + 1);

  adcc_ctrl_t ctrl;
  adcc_state_t state;
  adcc_state_t next_state;
  logic done;
  logic [1:0] curCh;
  logic [CNT_W-1:0] sampleCnt;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire regSel = bus.addr == CTRL_ONE_OFFSET;
  wire wrCtrl = bus.wr & regSel;
  wire rdCtrl = bus.rd & regSel;
  wire wrSamplingOne = wrCtrl & bus.wdata[BIT_SAMPLING];
  wire wrSamplingZero = wrCtrl & ~bus.wdata[BIT_SAMPLING];
  wire wrDoneZero = wrCtrl & ~bus.wdata[BIT_DONE];
  // unimplemented in 12-bit mode: write keeps old value
  wire newSimul = ctrl.resolution ? ctrl.simul
                                  : bus.wdata[BIT_SIMUL];

  adcc_ctrl_t wrVal;
  assign wrVal = '{
    enable: bus.wdata[BIT_ENABLE],
    idleStop: bus.wdata[BIT_IDLE_STOP],
    resolution: bus.wdata[BIT_RESOLUTION],
    format: bus.wdata[BIT_FORMAT_LO +: 2],
    source: bus.wdata[BIT_SOURCE_LO +: 3],
    simul: newSimul,
    autoStart: bus.wdata[BIT_AUTO]
  };

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire run = ctrl.enable & ~(ctrl.idleStop & idleMode);
  wire simEff = ctrl.simul & ~ctrl.resolution;
  wire sampling = state == ST_SAMPLE;
  wire inConv = state == ST_CONV;

  // last channel index of the group
  wire [1:0] lastCh = ctrl.resolution ? 2'h0
                    : (channelCount[1] ? 2'h3
                    : (channelCount[0] ? 2'h1 : 2'h0));
  wire [3:0] chSel = (lastCh == 2'h3) ? 4'hF
                   : ((lastCh == 2'h1) ? 4'h3 : 4'h1);

  // ----------------------------------------------------------------
  // trigger sources
  // ----------------------------------------------------------------
  logic pinEvt;
  logic timerEvt;

  adcc_edge #(
    .RISING(1'b1)
  ) u_pin_edge (
    .clk(clk),
    .rst(rst),
    .level(extPin),
    .pulse(pinEvt)
  );

  adcc_edge #(
    .RISING(1'b1)
  ) u_timer_edge (
    .clk(clk),
    .rst(rst),
    .level(timerCompare),
    .pulse(timerEvt)
  );

  wire cntDone = sampleCnt == CNT_W'(SAMPLE_CYCLES - 1);
  wire srcManual = ctrl.source == SRC_MANUAL;
  wire srcPin = ctrl.source == SRC_PIN;
  wire srcTimer = ctrl.source == SRC_TIMER;
  wire srcCounter = ctrl.source == SRC_COUNTER;

  // reserved codes match none of the terms
  wire hwEnd = (srcCounter & cntDone)
             | (srcTimer & timerEvt)
             | (srcPin & pinEvt);
  wire swEnd = srcManual & wrSamplingZero;
  wire endSample = run & sampling & (hwEnd | swEnd);

  wire convAck = run & inConv & convDone & ~convStart;
  wire lastConv = convAck & (curCh == lastCh);
  wire next_convStart = endSample | (convAck & ~lastConv);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    if (!run)
      next_state = ST_HOLD;
    else
    begin
      unique case (state)
        ST_HOLD:
          if (wrSamplingOne || ctrl.autoStart)
            next_state = ST_SAMPLE;
        ST_SAMPLE:
          if (endSample)
            next_state = ST_CONV;
        ST_CONV:
          if (lastConv)
            next_state = ctrl.autoStart ? ST_SAMPLE : ST_HOLD;
        default:
          next_state = ST_HOLD;
      endcase
    end
  end

  // set wins over a software clear in the same cycle
  wire next_done = lastConv ? 1'b1
                 : ((endSample | wrDoneZero) ? 1'b0 : done);

  wire [1:0] next_curCh = endSample ? 2'h0
                        : (convAck ? curCh + 2'h1 : curCh);

  wire countOn = run & sampling & srcCounter & ~endSample;
  wire [CNT_W-1:0] next_sampleCnt = countOn ? sampleCnt + CNT_W'(1)
                                            : '0;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl <= '0;
      state <= ST_HOLD;
      done <= 1'b0;
      curCh <= 2'h0;
      sampleCnt <= '0;
      convStart <= 1'b0;
    end
    else
    begin
      if (wrCtrl)
        ctrl <= wrVal;
      state <= next_state;
      done <= next_done;
      curCh <= next_curCh;
      sampleCnt <= next_sampleCnt;
      convStart <= next_convStart;
    end
  end

  // ----------------------------------------------------------------
  // sample-and-hold control
  // ----------------------------------------------------------------
  // sequential: channels not yet converted keep tracking
  wire [3:0] aheadMask = 4'(4'hE << curCh);
  wire [3:0] seqTrack = (inConv & ~simEff) ? aheadMask : 4'h0;
  // simultaneous: all selected channels hold at the same edge
  assign sampleHold = chSel & ({4{sampling}} | seqTrack);
  assign convChannel = curCh;
  assign converterOn = run;

  // ----------------------------------------------------------------
  // result path
  // ----------------------------------------------------------------
  adcc_format u_format (
    .clk(clk),
    .rst(rst),
    .inValid(convAck),
    .raw(convResult),
    .twelveBit(ctrl.resolution),
    .format(ctrl.format),
    .outData(resultData),
    .outValid(resultValid)
  );

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  wire [15:0] readWord = {ctrl.enable, 1'b0, ctrl.idleStop, 2'b00,
                          ctrl.resolution, ctrl.format, ctrl.source,
                          1'b0, simEff, ctrl.autoStart, sampling, done};

  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= CTRL_ONE_RESET;
    else
      rdata <= rdCtrl ? readWord : 16'h0000;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_off_holds: assert property (
    !ctrl.enable |=> state == ST_HOLD && !convStart && sampleHold == 4'h0)
    else $error("converter active while disabled");

  a_idle_stop: assert property (
    ctrl.enable && ctrl.idleStop && idleMode |=>
      state == ST_HOLD && !convStart)
    else $error("converter active in idle with stop set");

  a_one_channel: assert property (
    sampling && ctrl.resolution |-> sampleHold == 4'h1)
    else $error("12-bit mode uses more than one channel");

  a_counter_end: assert property (
    sampling && run && srcCounter && cntDone |=>
      state == ST_CONV && convStart && convChannel == 2'h0)
    else $error("internal counter did not end sampling");

  a_counter_span: assert property (
    $rose(sampling) && srcCounter && run && !wrCtrl ##1 run && !wrCtrl
      |-> sampling)
    else $error("internal counter ended sampling early");

  a_timer_end: assert property (
    sampling && run && srcTimer && timerEvt |=> state == ST_CONV)
    else $error("timer compare did not end sampling");

  a_pin_end: assert property (
    sampling && run && srcPin && pinEvt |=> state == ST_CONV)
    else $error("pin transition did not end sampling");

  a_manual_end: assert property (
    sampling && run && srcManual && wrSamplingZero |=>
      state == ST_CONV && !done && convStart)
    else $error("software clear did not start conversion");

  a_no_soft_end: assert property (
    sampling && run && !srcManual && !hwEnd |=> sampling)
    else $error("sampling ended without hardware trigger");

  a_simul_hold: assert property (
    inConv && simEff |-> sampleHold == 4'h0)
    else $error("simultaneous mode kept a channel tracking");

  a_seq_track: assert property (
    inConv && !simEff && lastCh == 2'h3 && curCh == 2'h1 |->
      sampleHold == 4'hC)
    else $error("sequential tracking mask wrong");

  a_simul_read: assert property (
    rdCtrl && ctrl.resolution |=> rdata[BIT_SIMUL] == 1'b0)
    else $error("simultaneous bit reads one in 12-bit mode");

  a_unimpl_zero: assert property (
    rdCtrl |=> rdata[14] == 1'b0 && rdata[12:11] == 2'b00 &&
      rdata[4] == 1'b0)
    else $error("unimplemented bit reads one");

  a_done_no_set: assert property (
    !done && !lastConv |=> !done)
    else $error("done set without a finished conversion");

  a_done_set: assert property (
    lastConv ##1 !endSample |-> done ##1 (done || endSample ||
      $past(wrDoneZero)))
    else $error("done not set at end of conversion");

  a_auto_restart: assert property (
    lastConv && ctrl.autoStart |=> sampling)
    else $error("auto-start did not resume sampling");

  a_reset_zero: assert property (
    $past(rst) |-> ctrl == '0 && !done && state == ST_HOLD)
    else $error("control bits not zero after reset");

endmodule

/* sim/testbench.sv */
/*
  Self-checking bench of the converter control block: register access,
  on/off and idle stop, formats, trigger sources, channel sequencing.
  Assumes the block's conversion engine is played by the bench itself.
*/
`timescale 1ns/10ps
module testbench;
  import adcc_pkg::*;
  localparam int SAMPLE_N = 4;
  logic clk;
  logic rst;
  adcc_bus_t bus;
  logic [15:0] rdata;
  logic idleMode;
  logic [1:0] channelCount;
  logic timerCompare;
  logic extPin;
  logic convDone;
  logic [11:0] convResult;
  logic [3:0] sampleHold;
  logic convStart;
  logic [1:0] convChannel;
  logic [15:0] resultData;
  logic resultValid;
  logic converterOn;
  int badCount;
  int nTests;
  int cycleCount;

  adcc_ctrl #(.SAMPLE_CYCLES(SAMPLE_N)) dut (
    .clk(clk),
    .rst(rst),
    .bus(bus),
    .rdata(rdata),
    .idleMode(idleMode),
    .channelCount(channelCount),
    .timerCompare(timerCompare),
    .extPin(extPin),
    .convDone(convDone),
    .convResult(convResult),
    .sampleHold(sampleHold),
    .convStart(convStart),
    .convChannel(convChannel),
    .resultData(resultData),
    .resultValid(resultValid),
    .converterOn(converterOn)
  );

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycleCount++;
    if (cycleCount == 20000)
    begin
      badCount++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task end_sim;
    if (badCount == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    nTests++;
    if (g !== e)
    begin
      badCount++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task rdchk(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask

  function automatic logic [15:0] fx(logic [11:0] r, bit tw, int f);
    if (f == 0)
      return tw ? {4'h0, r} : {6'h00, r[9:0]};
    if (f == 1)
      return tw ? {{5{~r[11]}}, r[10:0]} : {{7{~r[9]}}, r[8:0]};
    return 16'h0000;
  endfunction

  // plays the engine: one result per start
  task conv(input logic [1:0] ch, input logic [11:0] raw,
            input logic [15:0] e, input bit w);
    #1;
    if (w)
    begin
      for (int i = 0; i < 40 && convStart !== 1'b1; i++) @(posedge clk) #1;
      chk("convStart", 16'h0001, {15'h0000, convStart});
    end
    chk("convChannel", {14'h0000, ch}, {14'h0000, convChannel});
    @(posedge clk);
    convDone <= 1'b1;
    convResult <= raw;
    @(posedge clk);
    convDone <= 1'b0;
    #1;
    for (int i = 0; i < 3 && resultValid !== 1'b1; i++) @(posedge clk) #1;
    chk("resultValid", 16'h0001, {15'h0000, resultValid});
    chk("resultData", e, resultData);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rdchk(4'h0, 16'h0000);
    chk("converterOn", 16'h0000, {15'h0000, converterOn});
    wr(4'h5, 16'hFFFF);
    rdchk(4'h5, 16'h0000);
    rdchk(4'h0, 16'h0000);
    wr(4'h0, 16'h7FF9);
    rdchk(4'h0, 16'h27E0);
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h73F9);
    rdchk(4'h0, 16'h23E8);
    wr(4'h0, 16'h0002);
    rdchk(4'h0, 16'h0000);
  endtask

  task t_idle;
    wr(4'h0, 16'hA000);
    idleMode <= 1'b1;
    #1;
    chk("converterOn", 16'h0000, {15'h0000, converterOn});
    @(posedge clk);
    idleMode <= 1'b0;
    #1;
    chk("converterOn", 16'h0001, {15'h0000, converterOn});
    wr(4'h0, 16'h8000);
    idleMode <= 1'b1;
    #1;
    chk("converterOn", 16'h0001, {15'h0000, converterOn});
    wr(4'h0, 16'h0000);
    idleMode <= 1'b0;
    #1;
    chk("converterOn", 16'h0000, {15'h0000, converterOn});
  endtask

  task t_manual;
    logic [15:0] c;
    channelCount <= 2'h1;
    for (int f = 0; f < 3; f++)
    begin
      c = 16'h8008 | (16'(f) << 8);
      wr(4'h0, c);
      wr(4'h0, c | 16'h0002);
      #1;
      chk("sampleHold", 16'h0003, {12'h000, sampleHold});
      rdchk(4'h0, c | 16'h0002);
      wr(4'h0, c);
      #1;
      chk("sampleHold", 16'h0000, {12'h000, sampleHold});
      conv(2'h0, 12'h2A5, fx(12'h2A5, 1'b0, f), 1'b1);
      conv(2'h1, 12'h15A, fx(12'h15A, 1'b0, f), 1'b1);
      rdchk(4'h0, c | 16'h0001);
    end
    wr(4'h0, 16'h8002);
    wr(4'h0, 16'h8000);
    #1;
    chk("sampleHold", 16'h0002, {12'h000, sampleHold});
    conv(2'h0, 12'h001, 16'h0001, 1'b1);
    conv(2'h1, 12'h002, 16'h0002, 1'b1);
    channelCount <= 2'h2;
    wr(4'h0, 16'h800A);
    #1;
    chk("sampleHold", 16'h000F, {12'h000, sampleHold});
    wr(4'h0, 16'h8008);
    for (int k = 0; k < 4; k++)
      conv(2'(k), 12'(k + 7), 16'(k + 7), 1'b1);
  endtask

  task t_twelve;
    logic [15:0] c;
    logic [11:0] r;
    wr(4'h0, 16'h0000);
    wr(4'h0, 16'h0400);
    for (int f = 0; f < 2; f++)
    begin
      c = 16'h8400 | (16'(f) << 8);
      r = f ? 12'h35C : 12'hA5C;
      wr(4'h0, c | 16'h0008);
      rdchk(4'h0, c);
      wr(4'h0, c | 16'h000A);
      #1;
      chk("sampleHold", 16'h0001, {12'h000, sampleHold});
      wr(4'h0, c | 16'h0008);
      conv(2'h0, r, fx(r, 1'b1, f), 1'b1);
      rdchk(4'h0, c | 16'h0001);
    end
    wr(4'h0, 16'h0400);
    wr(4'h0, 16'h0000);
  endtask

  task t_trig;
    logic [2:0] s;
    logic [15:0] c;
    channelCount <= 2'h0;
    for (int k = 0; k < 4; k++)
    begin
      s = (k == 0) ? 3'h1 : (k == 1) ? 3'h2 : (k == 2) ? 3'h7 : 3'h3;
      c = 16'h8000 | (16'(s) << 5);
      wr(4'h0, c);
      wr(4'h0, c | 16'h0002);
      if (s != SRC_COUNTER)
        rdchk(4'h0, c | 16'h0002);
      @(posedge clk);
      extPin <= (s == SRC_PIN || s == 3'h3);
      timerCompare <= (s == SRC_TIMER || s == 3'h3);
      @(posedge clk);
      extPin <= 1'b0;
      timerCompare <= 1'b0;
      if (s == 3'h3)
      begin
        repeat (SAMPLE_N + 4) @(posedge clk);
        rdchk(4'h0, c | 16'h0002);
      end
      else
      begin
        conv(2'h0, 12'h3C3, 16'h03C3, 1'b1);
        rdchk(4'h0, c | 16'h0001);
      end
    end
    wr(4'h0, 16'h0000);
  endtask

  task t_auto;
    wr(4'h0, 16'h80E4);
    conv(2'h0, 12'h123, 16'h0123, 1'b1);
    rdchk(4'h0, 16'h80E7);
    for (int i = 0; i < 40 && convStart !== 1'b1; i++) @(posedge clk) #1;
    rdchk(4'h0, 16'h80E4);
    conv(2'h0, 12'h321, 16'h0321, 1'b0);
    wr(4'h0, 16'h0000);
    #1;
    chk("converterOn", 16'h0000, {15'h0000, converterOn});
    rdchk(4'h0, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    bus = '0;
    idleMode = 1'b0;
    channelCount = 2'h0;
    timerCompare = 1'b0;
    extPin = 1'b0;
    convDone = 1'b0;
    convResult = 12'h000;
    badCount = 0;
    nTests = 0;
    cycleCount = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_idle();
    t_manual();
    t_twelve();
    t_trig();
    t_auto();
    end_sim();
  end
endmodule
